// *** cetb_pkg.sv ***
/*
  Register indices, field positions, reset values and limits.
  Assumes a 32-bit bus, one register per aligned word.
*/
package cetb_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 9;
  localparam logic [6:0] IDX_MODE = 7'h00;
  localparam logic [6:0] IDX_STATUS = 7'h02;
  localparam logic [6:0] IDX_IRQ = 7'h03;
  localparam logic [6:0] IDX_IRQ_EN = 7'h04;
  localparam logic [6:0] IDX_ERR_CODE = 7'h0c;
  localparam logic [6:0] IDX_WARN_LIMIT = 7'h0d;
  localparam logic [6:0] IDX_RX_ERR = 7'h0e;
  localparam logic [6:0] IDX_TX_ERR = 7'h0f;
  localparam logic [6:0] IDX_BUF_FIRST = 7'h10;
  localparam logic [6:0] IDX_BUF_LAST = 7'h1c;
  localparam logic [6:0] IDX_RAM_FIRST = 7'h60;
  localparam logic [6:0] IDX_RAM_BUF_LAST = 7'h6c;
  localparam logic [6:0] IDX_RAM_LAST = 7'h6f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned MODE_RESET_BIT = 0;
  localparam int unsigned ST_BUS_OFF_BIT = 7;
  localparam int unsigned ST_WARN_BIT = 6;
  localparam int unsigned ST_PASSIVE_BIT = 5;
  localparam int unsigned IRQ_BUS_ERR_BIT = 7;
  localparam int unsigned IRQ_PASSIVE_BIT = 5;
  localparam int unsigned IRQ_WARN_BIT = 2;
  localparam int unsigned FI_FORMAT_BIT = 7;
  localparam int unsigned FI_REMOTE_BIT = 6;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam logic [7:0] WARN_LIMIT_RESET = 8'h60;
  localparam logic [7:0] ERR_CNT_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [7:0] PASSIVE_LIMIT = 8'h80;
  localparam logic [7:0] BUS_OFF_TX_LOAD = 8'h7f;
  localparam logic [7:0] FORCED_BUS_OFF = 8'hff;
  localparam logic [3:0] MAX_DATA_BYTES = 4'h8;
  localparam int unsigned BUF_BYTES = 13;
  localparam int unsigned RAM_BYTES = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** cetb_tx_ram.sv ***
/*
  Transmit staging RAM: 13 message bytes, 3 spare bytes.
  Assumes the caller checks address ranges.
*/
`timescale 1ns/10ps
module cetb_tx_ram
  import cetb_pkg::*;
#(
  parameter int unsigned DEPTH = RAM_BYTES
)
(
  input wire logic clock_in,
  input wire logic wr_en_in,
  input wire logic [3:0] wr_slot_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [3:0] host_slot_in,
  output logic [7:0] host_data_out,
  input wire logic [3:0] eng_slot_in,
  output logic [7:0] eng_data_out,
  output logic [7:0] frame_info_out
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // No reset: contents are undefined until software loads a message
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clock_in)
  begin
    if (wr_en_in)
      mem[wr_slot_in] <= wr_data_in;
  end

  assign host_data_out = mem[host_slot_in];
  assign eng_data_out = mem[eng_slot_in];
  assign frame_info_out = mem[0];

endmodule

// *** cetb_core.sv ***
/*
  CAN error bookkeeping and transmit staging behind an AXI4-Lite slave.
  Assumes a frame engine on the same clock giving one-cycle pulses.
*/
// The AXI4-Lite slave port was chosen for this implementation.
// What this block does
// R1 - Bus error sets its interrupt flag when enabled
// R2 - Bus error latches frame position into capture register
// R3 - Capture frozen until read once, then re-armed
// R4 - Interrupt register read clears bus error flag
// R5 - No new bus error interrupt before capture read
// R6 - Warning limit resets to 96
// R7 - Warning limit written only in reset mode
// R8 - New warning limit acts once reset mode ends
// R9 - Receive count live, resets zero, written only in reset mode
// R10 - Bus-off clears receive count and blocks writes to it
// R11 - Written receive count acts once reset mode ends
// R12 - Transmit count live, resets zero, written only in reset mode
// R13 - Bus-off loads transmit count 127, counts 128 bus-free events
// R14 - Write 0 to 254 in bus-off clears it; one bus-free wait
// R15 - Software forces bus-off writing 255 in reset mode
// R16 - Leaving reset mode at 255 does full bus-off entry
// R17 - Written transmit count acts once reset mode ends
// R18 - Leaving reset mode in bus-off runs 128 bus-free recovery
// R19 - Reset mode in recovery keeps bus-off, freezes count
// R20 - One 13-byte message at addresses 16 to 28
// R21 - Order: frame information, identifier bytes, data bytes
// R22 - RAM also at 96 to 108; 109 to 111 spare
// R23 - Frame information: format 7, remote 6, length 3..0
// R24 - Format one extended, remote one remote frame
// R25 - Length above eight sends eight, code unchanged
// R26 - Capture read-only: type 7..6, direction 5, segment 4..0
// R27 - Warning status when either counter reaches limit
`timescale 1ns/10ps
module cetb_core
  import cetb_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  input wire logic bus_error_in,
  input wire logic [7:0] error_code_in,
  input wire logic rx_err_inc1_in,
  input wire logic rx_err_inc8_in,
  input wire logic rx_err_dec_in,
  input wire logic tx_err_inc8_in,
  input wire logic tx_err_dec_in,
  input wire logic bus_free_in,
  input wire logic [3:0] eng_slot_in,
  output logic [7:0] eng_data_out,
  output logic frame_format_flag_out,
  output logic remote_frame_out,
  output logic [3:0] dlc_out,
  output logic [3:0] data_byte_count_out,
  output logic reset_mode_out,
  output logic bus_off_out,
  output logic error_warning_out,
  output logic error_passive_out,
  output logic node_active_out,
  output logic [7:0] irq_flags_out
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Counter step; nine bits so a transmit overflow past 255 is visible
  function automatic logic [8:0] err_step(input logic [7:0] cnt,
                                          input logic inc1,
                                          input logic inc8,
                                          input logic dec);
    logic [8:0] sum;
    sum = {1'b0, cnt};
    if (inc8)
      sum = sum + 9'h008;
    else if (inc1)
      sum = sum + 9'h001;
    else if (dec && cnt != 8'h00)
      sum = sum - 9'h001;
    return sum;
  endfunction

  function automatic logic in_range(input logic [6:0] idx,
                                    input logic [6:0] lo,
                                    input logic [6:0] hi);
    return (idx >= lo) && (idx <= hi);
  endfunction

  function automatic logic mapped(input logic [6:0] idx);
    return (idx inside {IDX_MODE, IDX_STATUS, IDX_IRQ, IDX_IRQ_EN,
                        IDX_ERR_CODE, IDX_WARN_LIMIT, IDX_RX_ERR,
                        IDX_TX_ERR}) ||
           in_range(idx, IDX_BUF_FIRST, IDX_BUF_LAST) ||
           in_range(idx, IDX_RAM_FIRST, IDX_RAM_LAST);
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [6:0] aw_idx_reg;
  logic [7:0] wdata_reg;
  logic wstrb0_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic reset_mode_reg, bus_off_reg, warn_reg, passive_reg;
  logic bus_wait_reg, capture_armed_reg, node_active_reg;
  logic [7:0] ecc_reg, lim_reg, rx_cnt_reg, tx_cnt_reg, irq_reg, irq_en_reg;
  logic format_reg, remote_reg;
  logic [3:0] dlc_reg, count_reg;
  logic [7:0] eng_data_reg;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  wire aw_take = s_axi_awvalid_in && awready_reg;
  wire w_take = s_axi_wvalid_in && wready_reg;
  wire do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire aw_hold_next = (aw_hold_reg || aw_take) && !do_write;
  wire w_hold_next = (w_hold_reg || w_take) && !do_write;
  wire bvalid_next = do_write || (bvalid_reg && !s_axi_bready_in);
  wire ar_take = s_axi_arvalid_in && arready_reg;
  wire rvalid_next = ar_take || (rvalid_reg && !s_axi_rready_in);
  wire [6:0] ar_idx = s_axi_araddr_in[8:2];
  wire [6:0] aw_idx_in = s_axi_awaddr_in[8:2];

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  wire wr = do_write && wstrb0_reg;
  wire [6:0] widx = aw_idx_reg;
  wire w_buf = in_range(widx, IDX_BUF_FIRST, IDX_BUF_LAST); // R20
  wire w_ram = in_range(widx, IDX_RAM_FIRST, IDX_RAM_LAST); // R22
  wire w_mapped = mapped(widx);
  wire wr_mode = wr && (widx == IDX_MODE);
  wire wr_irq_en = wr && (widx == IDX_IRQ_EN);
  wire wr_lim = wr && (widx == IDX_WARN_LIMIT) && reset_mode_reg; // R7
  wire wr_rx = wr && (widx == IDX_RX_ERR) && reset_mode_reg &&
               !bus_off_reg; // R9 R10
  wire wr_tx = wr && (widx == IDX_TX_ERR) && reset_mode_reg; // R12
  wire ram_wr = wr && (w_buf || w_ram);
  wire [3:0] ram_wslot = w_buf ? 4'(widx - IDX_BUF_FIRST)
                               : 4'(widx - IDX_RAM_FIRST);

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  wire r_ram = in_range(ar_idx, IDX_RAM_FIRST, IDX_RAM_LAST); // R22
  wire [3:0] ram_rslot = 4'(ar_idx - IDX_RAM_FIRST);
  wire [7:0] ram_rdata;
  wire [7:0] eng_byte;
  wire [7:0] frame_info;
  wire rd_irq = ar_take && (ar_idx == IDX_IRQ); // R4
  wire rd_ecc = ar_take && (ar_idx == IDX_ERR_CODE); // R3
  wire [7:0] status_val = {bus_off_reg, warn_reg, passive_reg, 5'h00};
  wire r_mapped = mapped(ar_idx);
  // Buffer window at 16..28 is write-only; direct RAM window reads back
  wire [7:0] rd_byte =
    (ar_idx == IDX_MODE) ? {7'h00, reset_mode_reg} :
    (ar_idx == IDX_STATUS) ? status_val :
    (ar_idx == IDX_IRQ) ? irq_reg :
    (ar_idx == IDX_IRQ_EN) ? irq_en_reg :
    (ar_idx == IDX_ERR_CODE) ? ecc_reg : // R26
    (ar_idx == IDX_WARN_LIMIT) ? lim_reg :
    (ar_idx == IDX_RX_ERR) ? rx_cnt_reg : // R9
    (ar_idx == IDX_TX_ERR) ? tx_cnt_reg : // R12 R13
    r_ram ? ram_rdata : 8'h00;

  // ----------------------------------------------------------------
  // Error counters and bus-off
  // ----------------------------------------------------------------
  wire counting = !reset_mode_reg && !bus_off_reg && !bus_wait_reg;
  wire [8:0] rx_step = err_step(rx_cnt_reg, rx_err_inc1_in,
                                rx_err_inc8_in, rx_err_dec_in);
  wire [8:0] tx_step = err_step(tx_cnt_reg, 1'b0, tx_err_inc8_in,
                                tx_err_dec_in);
  wire leave_reset = wr_mode && !wdata_reg[MODE_RESET_BIT] &&
                     reset_mode_reg;
  wire forced_off = leave_reset && !bus_off_reg &&
                    (tx_cnt_reg == FORCED_BUS_OFF); // R16
  wire real_off = counting && tx_step[8]; // R13
  wire enter_off = real_off || forced_off;
  wire recovering = bus_off_reg && !reset_mode_reg; // R18 R19
  wire recover_done = recovering && bus_free_in &&
                      (tx_cnt_reg == 8'h00); // R13
  wire wr_tx_clear = wr_tx && bus_off_reg &&
                     (wdata_reg != FORCED_BUS_OFF); // R14

  logic [7:0] rx_cnt_next, tx_cnt_next;
  logic bus_off_next, reset_mode_next, bus_wait_next;

  always_comb
  begin
    rx_cnt_next = rx_cnt_reg;
    tx_cnt_next = tx_cnt_reg;
    bus_off_next = bus_off_reg;
    reset_mode_next = reset_mode_reg;
    bus_wait_next = bus_wait_reg;
    if (wr_mode)
      reset_mode_next = wdata_reg[MODE_RESET_BIT];
    if (counting)
    begin
      rx_cnt_next = rx_step[8] ? 8'hff : rx_step[7:0];
      tx_cnt_next = tx_step[7:0];
    end
    if (wr_rx)
      rx_cnt_next = wdata_reg; // R9
    if (wr_tx)
      tx_cnt_next = wdata_reg; // R12 R15
    if (wr_tx_clear)
    begin
      bus_off_next = 1'b0; // R14
      bus_wait_next = 1'b1; // R14
    end
    if (recovering && bus_free_in && tx_cnt_reg != 8'h00)
      tx_cnt_next = tx_cnt_reg - 8'h01; // R18
    if (recover_done)
    begin
      bus_off_next = 1'b0;
      rx_cnt_next = ERR_CNT_RESET;
    end
    if (bus_wait_reg && !reset_mode_reg && bus_free_in)
      bus_wait_next = 1'b0; // R14
    if (enter_off)
    begin
      bus_off_next = 1'b1; // R13 R16
      reset_mode_next = 1'b1; // R16
      tx_cnt_next = BUS_OFF_TX_LOAD; // R13 R16
      rx_cnt_next = ERR_CNT_RESET; // R10 R16
      bus_wait_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupt flags
  // ----------------------------------------------------------------
  // Status follows counters only outside reset mode, so host-written
  // values take effect when reset mode is cancelled
  wire warn_now = (rx_cnt_reg >= lim_reg) ||
                  (tx_cnt_reg >= lim_reg) || bus_off_reg; // R27
  wire passive_now = (rx_cnt_reg >= PASSIVE_LIMIT) ||
                     (tx_cnt_reg >= PASSIVE_LIMIT);
  wire status_live = !reset_mode_reg; // R8 R11 R17
  wire warn_next = status_live ? warn_now : warn_reg;
  wire passive_next = status_live ? passive_now : passive_reg;
  wire bus_err_set = bus_error_in && capture_armed_reg &&
                     irq_en_reg[IRQ_BUS_ERR_BIT]; // R1 R5
  wire warn_set = (warn_next != warn_reg) && irq_en_reg[IRQ_WARN_BIT];
  wire passive_set = (passive_next != passive_reg) &&
                     irq_en_reg[IRQ_PASSIVE_BIT];
  // Set wins over the clear of an interrupt register read
  wire [7:0] irq_set = {bus_err_set, 1'b0, passive_set, 2'h0,
                        warn_set, 2'h0};
  wire [7:0] irq_next = (rd_irq ? 8'h00 : irq_reg) | irq_set; // R4
  wire armed_next = (capture_armed_reg && !bus_error_in) ||
                    rd_ecc; // R3

  // ----------------------------------------------------------------
  // Transmit frame decode
  // ----------------------------------------------------------------
  wire [3:0] fi_dlc = frame_info[3:0]; // R23
  wire [3:0] fi_count = frame_info[FI_REMOTE_BIT] ? 4'h0 :
                        (fi_dlc > MAX_DATA_BYTES) ? MAX_DATA_BYTES :
                        fi_dlc; // R25

  cetb_tx_ram #(
    .DEPTH(RAM_BYTES)
  ) u_ram (
    .clock_in(clock_in),
    .wr_en_in(ram_wr),
    .wr_slot_in(ram_wslot),
    .wr_data_in(wdata_reg),
    .host_slot_in(ram_rslot),
    .host_data_out(ram_rdata),
    .eng_slot_in(eng_slot_in),
    .eng_data_out(eng_byte),
    .frame_info_out(frame_info)
  ); // R20 R21

  // ----------------------------------------------------------------
  // Bus slave flops
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      arready_reg <= 1'b0;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awready_reg <= !aw_hold_next && !bvalid_next;
      wready_reg <= !w_hold_next && !bvalid_next;
      bvalid_reg <= bvalid_next;
      rvalid_reg <= rvalid_next;
      arready_reg <= !rvalid_next;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      aw_idx_reg <= 7'h00;
      wdata_reg <= 8'h00;
      wstrb0_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end
    else
    begin
      if (aw_take)
        aw_idx_reg <= aw_idx_in;
      if (w_take)
        wdata_reg <= s_axi_wdata_in[7:0];
      if (w_take)
        wstrb0_reg <= s_axi_wstrb_in[0];
      if (do_write)
        bresp_reg <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      if (ar_take)
        rdata_reg <= {24'h00_0000, rd_byte};
      if (ar_take)
        rresp_reg <= r_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // Error bookkeeping flops
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      reset_mode_reg <= MODE_RESET[MODE_RESET_BIT];
      bus_off_reg <= 1'b0;
      bus_wait_reg <= 1'b0;
      rx_cnt_reg <= ERR_CNT_RESET; // R9
      tx_cnt_reg <= ERR_CNT_RESET; // R12
      lim_reg <= WARN_LIMIT_RESET; // R6
      warn_reg <= 1'b0;
      passive_reg <= 1'b0;
      irq_reg <= 8'h00;
      irq_en_reg <= 8'h00;
      ecc_reg <= 8'h00;
      capture_armed_reg <= 1'b1;
      node_active_reg <= 1'b0;
    end
    else
    begin
      reset_mode_reg <= reset_mode_next;
      bus_off_reg <= bus_off_next;
      bus_wait_reg <= bus_wait_next;
      rx_cnt_reg <= rx_cnt_next;
      tx_cnt_reg <= tx_cnt_next;
      warn_reg <= warn_next;
      passive_reg <= passive_next;
      irq_reg <= irq_next;
      capture_armed_reg <= armed_next;
      node_active_reg <= !reset_mode_next && !bus_off_next &&
                         !bus_wait_next;
      if (wr_lim)
        lim_reg <= wdata_reg; // R7
      if (wr_irq_en)
        irq_en_reg <= wdata_reg;
      if (bus_error_in && capture_armed_reg)
        ecc_reg <= error_code_in; // R2 R3
    end
  end

  // ----------------------------------------------------------------
  // Frame engine outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      format_reg <= 1'b0;
      remote_reg <= 1'b0;
      dlc_reg <= 4'h0;
      count_reg <= 4'h0;
      eng_data_reg <= 8'h00;
    end
    else
    begin
      format_reg <= frame_info[FI_FORMAT_BIT]; // R24
      remote_reg <= frame_info[FI_REMOTE_BIT]; // R24
      dlc_reg <= fi_dlc; // R25
      count_reg <= fi_count;
      eng_data_reg <= eng_byte;
    end
  end

  assign s_axi_awready_out = awready_reg;
  assign s_axi_wready_out = wready_reg;
  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out = bresp_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out = rdata_reg;
  assign s_axi_rresp_out = rresp_reg;
  assign eng_data_out = eng_data_reg;
  assign frame_format_flag_out = format_reg;
  assign remote_frame_out = remote_reg;
  assign dlc_out = dlc_reg;
  assign data_byte_count_out = count_reg;
  assign reset_mode_out = reset_mode_reg;
  assign bus_off_out = bus_off_reg;
  assign error_warning_out = warn_reg;
  assign error_passive_out = passive_reg;
  assign irq_flags_out = irq_reg;
  assign node_active_out = node_active_reg;

endmodule

// *** cetb_monitor.sv ***
/* Checker for the ports of cetb_core.
   Assumes it is bound to every cetb_core instance. */
`timescale 1ns/10ps
module cetb_monitor
  import cetb_pkg::*;
(
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic bus_error_in,
  input wire logic remote_frame_out,
  input wire logic [3:0] dlc_out,
  input wire logic [3:0] data_byte_count_out,
  input wire logic reset_mode_out,
  input wire logic bus_off_out,
  input wire logic node_active_out,
  input wire logic [7:0] irq_flags_out
);
  wire rd_irq = s_axi_arvalid_in && s_axi_arready_out &&
    s_axi_araddr_in[8:2] == IDX_IRQ;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  a_irq_cause: assert property ($rose(irq_flags_out[7])
    |-> $past(bus_error_in)) else $error("irq flag without bus error");
  a_irq_clear: assert property (rd_irq && !bus_error_in
    |=> !irq_flags_out[7]) else $error("irq flag kept after read");
  a_irq_hold: assert property (irq_flags_out[7] && !rd_irq
    |=> irq_flags_out[7]) else $error("irq flag lost without read");
  a_busoff_mode: assert property ($rose(bus_off_out)
    |-> reset_mode_out) else $error("bus-off without reset mode");
  a_busoff_idle: assert property (bus_off_out
    |-> !node_active_out) else $error("node active in bus-off");
  a_remote_none: assert property (remote_frame_out
    |-> data_byte_count_out == 4'h0) else $error("remote with data");
  a_dlc_clamp: assert property (!remote_frame_out |->
    data_byte_count_out == ((dlc_out > MAX_DATA_BYTES) ?
    MAX_DATA_BYTES : dlc_out)) else $error("data count wrong");
  a_busoff_frozen: assert property (bus_off_out && reset_mode_out
    && s_axi_awready_out |=> bus_off_out) else $error("bus-off dropped");
endmodule

// *** cetb_host.sv ***
/* Host register master model speaking AXI4-Lite to cetb_core.
   Assumes the bench calls xfer and watches host_hang_out. */
`timescale 1ns/10ps
module cetb_host
  import cetb_pkg::*;
(
  input wire logic clock_in,
  output logic s_axi_awvalid_in = 1'h0,
  input wire logic s_axi_awready_out,
  output logic [ADDR_W-1:0] s_axi_awaddr_in = '0,
  output logic s_axi_wvalid_in = 1'h0,
  input wire logic s_axi_wready_out,
  output logic [31:0] s_axi_wdata_in = 32'h0,
  input wire logic s_axi_bvalid_out,
  output logic s_axi_bready_in = 1'h0,
  output logic s_axi_arvalid_in = 1'h0,
  input wire logic s_axi_arready_out,
  output logic [ADDR_W-1:0] s_axi_araddr_in = '0,
  input wire logic s_axi_rvalid_out,
  output logic s_axi_rready_in = 1'h0,
  output logic host_hang_out = 1'h0
);
  // Each channel released only at the edge that takes it
  task automatic xfer(input logic wr, input logic [6:0] idx,
    input logic [7:0] dat);
    int n;
    n = 0;
    @(posedge clock_in);
    s_axi_awaddr_in <= {idx, 2'h0};
    s_axi_araddr_in <= {idx, 2'h0};
    s_axi_wdata_in <= {24'h0, dat};
    s_axi_awvalid_in <= wr;
    s_axi_wvalid_in <= wr;
    s_axi_bready_in <= wr;
    s_axi_arvalid_in <= !wr;
    s_axi_rready_in <= !wr;
    do
    begin
      @(posedge clock_in);
      n++;
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
    end
    while (!(wr ? s_axi_bvalid_out : s_axi_rvalid_out) && n < 200);
    s_axi_bready_in <= 1'h0;
    s_axi_rready_in <= 1'h0;
    host_hang_out <= (n >= 200);
  endtask
endmodule

// *** tb_can_error_counters_tx_buffer.sv ***
/* Self-checking bench for cetb_core, reads checked from a queue.
   Assumes cetb_host as register master and cetb_monitor bound in. */
`timescale 1ns/10ps
`define CK(n, e, a) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_can_error_counters_tx_buffer
  import cetb_pkg::*;
;
  logic clock_in = 1'h0;
  logic arst_n_in = 1'h0;
  logic s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
  logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out;
  logic s_axi_rready_in, host_hang_out, bus_error_in, bus_free_in;
  logic rx_err_inc1_in, rx_err_inc8_in, rx_err_dec_in;
  logic tx_err_inc8_in, tx_err_dec_in, frame_format_flag_out;
  logic remote_frame_out, reset_mode_out, bus_off_out;
  logic error_warning_out, error_passive_out, node_active_out;
  logic [ADDR_W-1:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [2:0] s_axi_awprot_in = 3'h0, s_axi_arprot_in = 3'h0;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in = 4'hf, eng_slot_in = 4'h0;
  logic [3:0] dlc_out, data_byte_count_out, exp_cnt;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [7:0] error_code_in = 8'h00, eng_data_out, irq_flags_out;
  logic [7:0] fi, c1, c2;
  logic [6:0] ev = 7'h00;
  logic [9:0] q[$];
  logic [9:0] exp_rd;
  int err_count = 0;
  int checked = 0;
  assign {bus_error_in, bus_free_in, tx_err_dec_in, tx_err_inc8_in,
    rx_err_dec_in, rx_err_inc8_in, rx_err_inc1_in} = ev;
  cetb_core cetb_core_inst (.*);
  cetb_host cetb_host_inst (.*);
  initial forever #5 clock_in = ~clock_in;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    cetb_host_inst.xfer(1'h1, i, d);
  endtask
  task automatic rc(input logic [6:0] i, input logic [9:0] e);
    q.push_back(e);
    cetb_host_inst.xfer(1'h0, i, 8'h00);
  endtask
  task automatic pulse(input int b, input int k);
    repeat (k)
    begin
      @(posedge clock_in);
      ev[b] <= 1'h1;
      @(posedge clock_in);
      ev[b] <= 1'h0;
    end
    repeat (3) @(posedge clock_in);
  endtask
  always @(posedge clock_in)
    if (s_axi_rvalid_out && s_axi_rready_in)
    begin
      exp_rd = q.pop_front();
      `CK("read", exp_rd, {s_axi_rresp_out, s_axi_rdata_out[7:0]})
    end
  always @(posedge clock_in)
    if (s_axi_bvalid_out && s_axi_bready_in)
      `CK("bresp", RESP_OKAY, s_axi_bresp_out)
  always @(posedge host_hang_out)
  begin
    err_count++;
    end_sim();
  end
  initial
  begin
    fi = $urandom(34);
    repeat (5) @(posedge clock_in);
    arst_n_in <= 1'h1;
    rc(IDX_WARN_LIMIT, WARN_LIMIT_RESET);
    rc(IDX_RX_ERR, ERR_CNT_RESET);
    rc(IDX_TX_ERR, ERR_CNT_RESET);
    rc(7'h05, {RESP_SLVERR, 8'h00});
    wr(IDX_WARN_LIMIT, 8'h20);
    rc(IDX_WARN_LIMIT, 8'h20);
    wr(IDX_MODE, 8'h00);
    wr(IDX_WARN_LIMIT, 8'h60);
    rc(IDX_WARN_LIMIT, 8'h20);
    pulse(5, 1);
    pulse(1, 4);
    `CK("warn", 1'h1, error_warning_out);
    pulse(2, 1);
    `CK("warn", 1'h0, error_warning_out);
    pulse(0, 1);
    pulse(3, 2);
    pulse(4, 1);
    rc(IDX_RX_ERR, 8'h20);
    rc(IDX_TX_ERR, 8'h0f);
    $display("test counters done");
    wr(IDX_IRQ_EN, 8'h80);
    c1 = $urandom;
    c2 = ~c1;
    error_code_in <= c1;
    pulse(6, 1);
    rc(IDX_IRQ, 8'h80);
    error_code_in <= c2;
    pulse(6, 1);
    rc(IDX_IRQ, 8'h00);
    rc(IDX_ERR_CODE, c1);
    pulse(6, 1);
    rc(IDX_ERR_CODE, c2);
    $display("test bus error done");
    wr(IDX_MODE, 8'h01);
    wr(IDX_TX_ERR, FORCED_BUS_OFF);
    wr(IDX_MODE, 8'h00);
    pulse(5, 0);
    `CK("bus_off", 1'h1, bus_off_out);
    `CK("reset_mode", 1'h1, reset_mode_out);
    rc(IDX_TX_ERR, BUS_OFF_TX_LOAD);
    wr(IDX_RX_ERR, 8'h05);
    rc(IDX_RX_ERR, 8'h00);
    wr(IDX_MODE, 8'h00);
    pulse(5, 10);
    wr(IDX_MODE, 8'h01);
    pulse(5, 3);
    rc(IDX_TX_ERR, BUS_OFF_TX_LOAD - 8'h0a);
    wr(IDX_MODE, 8'h00);
    pulse(5, BUS_OFF_TX_LOAD - 10);
    `CK("bus_off", 1'h1, bus_off_out);
    pulse(5, 1);
    `CK("bus_off", 1'h0, bus_off_out);
    wr(IDX_MODE, 8'h01);
    wr(IDX_TX_ERR, FORCED_BUS_OFF);
    wr(IDX_MODE, 8'h00);
    wr(IDX_TX_ERR, 8'h00);
    wr(IDX_MODE, 8'h00);
    pulse(5, 0);
    `CK("bus_off", 1'h0, bus_off_out);
    `CK("active", 1'h0, node_active_out);
    pulse(5, 1);
    `CK("active", 1'h1, node_active_out);
    $display("test bus-off done");
    for (int i = 0; i < 6; i++)
    begin
      fi = $urandom;
      if (i == 0) fi[3:0] = 4'hb;
      c1 = ~fi;
      exp_cnt = fi[6] ? 4'h0 : (fi[3:0] > MAX_DATA_BYTES) ?
        MAX_DATA_BYTES : fi[3:0];
      wr(IDX_BUF_FIRST, fi);
      pulse(5, 0);
      `CK("format", fi[7], frame_format_flag_out);
      `CK("remote", fi[6], remote_frame_out);
      `CK("dlc", fi[3:0], dlc_out);
      `CK("count", exp_cnt, data_byte_count_out);
      `CK("engine", fi, eng_data_out);
      rc(IDX_RAM_FIRST, fi);
      rc(IDX_BUF_FIRST, 8'h00);
      wr(IDX_BUF_LAST, c1);
      rc(IDX_RAM_BUF_LAST, c1);
      wr(IDX_RAM_LAST, fi);
      rc(IDX_RAM_LAST, fi);
    end
    $display("test buffer done");
    pulse(5, 0);
    end_sim();
  end
endmodule
bind cetb_core cetb_monitor cetb_monitor_inst (.*);
